// *** hdl/nv_command_control.sv ***
// host command and status control for the serial nonvolatile memory
// assumes an external link engine and boot loader beside it, one clock
// assumes link_done, link_nack and loader_done arrive as one-cycle pulses
// assumes the host waits for busy to clear before the next command
//
// Functional notes
// - writing one to bit 31 starts the selected operation
// - busy holds until the operation ends, then self-clears
// - write without memory: busy clears exactly when timeout sets
// - busy forced on after power-up, pin reset and soft reset
// - busy clears once the boot loader finishes
// - bits 30:28 run only with busy set; 000 read, 001 reserved
module nv_command_control
#(
	parameter int unsigned TIMEOUT_LIMIT = nv_cmd_pkg::TIMEOUT_CYCLES
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic [11:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic soft_reset,
	input wire logic loader_done,
	output logic reload_req,
	output logic link_start,
	output logic link_write,
	output logic [nv_cmd_pkg::EE_ADDR_W-1:0] link_addr,
	output logic [nv_cmd_pkg::DATA_W-1:0] link_wdata,
	input wire logic link_done,
	input wire logic link_nack,
	input wire logic [nv_cmd_pkg::DATA_W-1:0] link_rdata,
	output logic irq
);

	import nv_cmd_pkg::*;

	// command word: busy 31, op 30:28, zeros 27:10, timeout 9, addr 8:0
	// data word: byte in 7:0; status and mask: done 0, timeout 1, boot 2
	// status clears on read; the timeout bit clears on a written one
	// unmapped offsets read as zero and ignore writes
	ctl_s q;
	ctl_s d;
	logic tmo_expired;
	logic start_req;
	logic [2:0] new_op;

	// watchdog runs only while a link operation is outstanding
	nv_timeout_timer #(
		.LIMIT(TIMEOUT_LIMIT)
	) u_timer (
		.clk(clk),
		.rst_n(rst_n),
		.ce(ce),
		.run(q.st == ST_LINK),
		.expired(tmo_expired)
	);

	// a start only counts when idle; start writes while busy are dropped
	assign new_op = reg_wdata[OP_HI:OP_LO];
	assign start_req = reg_wr && (reg_addr == REG_CMD) && !q.busy &&
		reg_wdata[BUSY_BIT];

	// next state: reads and writes first, hardware events last so sets win
	always_comb begin
		d = q;
		d.link_start = 1'b0;
		d.reload_req = 1'b0;
		d.rdata = 32'h0000_0000;

		// register reads, data valid the following cycle only
		if (reg_rd) begin
			case (reg_addr)
				REG_CMD: begin
					d.rdata = {q.busy, q.op, 18'h0_0000, q.tmo, q.ee_addr};
				end
				REG_DATA: begin
					d.rdata = {24'h00_0000, q.data};
				end
				REG_ISTAT: begin
					d.rdata = {29'h0000_0000, q.istat};
					d.istat = 3'h0; // read clears
				end
				REG_IMASK: begin
					d.rdata = {29'h0000_0000, q.imask};
				end
				default: begin
					d.rdata = 32'h0000_0000;
				end
			endcase
		end

		// register writes
		if (reg_wr) begin
			case (reg_addr)
				REG_CMD: begin
					if (reg_wdata[TMO_BIT]) begin
						d.tmo = 1'b0; // write one to clear
					end
					// fields frozen while busy; protects the op in flight
					if (!q.busy) begin
						d.op = new_op;
						d.ee_addr = reg_wdata[EE_ADDR_W-1:0];
					end
				end
				REG_DATA: begin
					if (!q.busy) begin
						d.data = reg_wdata[DATA_W-1:0];
					end
				end
				REG_IMASK: begin
					d.imask = reg_wdata[IRQ_W-1:0];
				end
				default: begin
				end
			endcase
		end

		// operation launch
		if (start_req) begin
			if (op_uses_link(new_op)) begin
				d.busy = 1'b1;
				d.st = ST_LINK;
				d.link_start = 1'b1;
			end else if (new_op == OP_RELOAD) begin
				d.busy = 1'b1;
				d.st = ST_BOOT;
				d.reload_req = 1'b1;
			end
			// reserved codes finish at once with no access
		end

		// completion handling; a done beats a nack or expiry in one cycle
		// so a late answer still delivers its data
		case (q.st)
			ST_IDLE: begin
			end
			ST_LINK: begin
				if (link_done) begin
					d.busy = 1'b0;
					d.st = ST_IDLE;
					if (q.op == OP_READ) begin
						d.data = link_rdata;
					end
					d.istat[IRQ_DONE] = 1'b1;
				end else if (link_nack || tmo_expired) begin
					// flag and busy move in the same edge
					d.tmo = 1'b1;
					d.busy = 1'b0;
					d.st = ST_IDLE;
					d.istat[IRQ_TMO] = 1'b1;
				end
			end
			ST_BOOT: begin
				if (loader_done) begin
					d.busy = 1'b0;
					d.st = ST_IDLE;
					d.istat[IRQ_BOOT] = 1'b1;
				end
			end
			default: begin
				d.st = ST_IDLE;
			end
		endcase

		// soft reset blocks the host until the loader runs again
		// it drops an operation in flight without flagging a timeout
		if (soft_reset) begin
			d.busy = 1'b1;
			d.st = ST_BOOT;
			d.link_start = 1'b0;
			d.reload_req = 1'b0;
		end
	end

	// reset state has busy set and waits for the loader
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= CTL_RST;
		end else if (ce) begin
			q <= d;
		end
	end

	// outputs straight from the state register
	assign reg_rdata = q.rdata;
	assign reload_req = q.reload_req;
	assign link_start = q.link_start;
	assign link_write = (q.op == OP_WRITE);
	assign link_addr = q.ee_addr;
	assign link_wdata = q.data;
	assign irq = |(q.istat & q.imask);

	// checks
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	a_boot_busy: assert property (q.st == ST_BOOT |-> q.busy)
		else $error("busy low while waiting for loader");

	a_soft_reset_busy: assert property (
		ce && soft_reset |=> q.busy && q.st == ST_BOOT)
		else $error("soft reset did not set busy");

	a_start_link: assert property (
		ce && start_req && op_uses_link(new_op) &&
		!soft_reset
		|=> q.busy && link_start && q.op == $past(new_op))
		else $error("start did not launch link operation");

	a_busy_hold: assert property (
		ce && q.st == ST_LINK && !link_done && !link_nack &&
		!tmo_expired && !soft_reset |=> q.busy && q.st == ST_LINK)
		else $error("busy dropped before completion");

	a_done_clears: assert property (
		ce && q.st == ST_LINK && link_done && !soft_reset
		|=> !q.busy && q.st == ST_IDLE)
		else $error("busy not cleared on completion");

	a_timeout_same: assert property (
		$rose(q.tmo) |-> $fell(q.busy))
		else $error("timeout and busy clear not together");

	a_loader_clears: assert property (
		ce && q.st == ST_BOOT && loader_done && !soft_reset |=> !q.busy)
		else $error("loader done did not clear busy");

	a_link_busy: assert property (link_start |-> q.busy)
		else $error("link started without busy");

	a_reserved_quiet: assert property (
		ce && start_req && !op_known(new_op) &&
		!soft_reset
		|=> !link_start && !reload_req && !q.busy)
		else $error("reserved code touched the link");

	a_read_data: assert property (
		ce && q.st == ST_LINK && link_done && q.op == OP_READ &&
		!soft_reset |=> q.data == $past(link_rdata))
		else $error("read data not captured");

	// data, read-back and idle checks
	a_write_keeps_data: assert property (
		ce && q.st == ST_LINK && link_done && q.op != OP_READ &&
		!soft_reset |=> q.data == $past(q.data))
		else $error("write completion disturbed the data byte");

	a_busy_readback: assert property (
		ce && reg_rd && reg_addr == REG_CMD
		|=> reg_rdata[BUSY_BIT] == $past(q.busy))
		else $error("busy bit read back wrong");

	a_rdata_zero: assert property (
		ce && !reg_rd |=> reg_rdata == 32'h0000_0000)
		else $error("read data stood beyond its cycle");

	a_idle_not_busy: assert property (
		q.st == ST_IDLE |-> !q.busy)
		else $error("busy set with nothing in flight");

	// timeout, refusal and boot checks
	a_timeout_flag: assert property (
		ce && q.st == ST_LINK && !link_done &&
		(link_nack || tmo_expired) && !soft_reset
		|=> q.tmo && !q.busy && q.st == ST_IDLE)
		else $error("timeout did not end the operation");

	a_fields_frozen: assert property (
		ce && reg_wr && q.busy && !soft_reset
		|=> q.op == $past(q.op) && q.ee_addr == $past(q.ee_addr))
		else $error("command fields changed while busy");

	a_no_start_bit: assert property (
		ce && reg_wr && reg_addr == REG_CMD &&
		!reg_wdata[BUSY_BIT] && q.st == ST_IDLE && !soft_reset
		|=> !q.busy && !link_start && !reload_req)
		else $error("command ran without the start bit");

	a_reload_start: assert property (
		ce && start_req && new_op == OP_RELOAD && !soft_reset
		|=> q.busy && reload_req && q.st == ST_BOOT)
		else $error("reload code did not start the loader");

	a_boot_waits: assert property (
		ce && q.st == ST_BOOT && !loader_done && !soft_reset
		|=> q.busy && q.st == ST_BOOT)
		else $error("boot wait ended without the loader");

	// main scenarios
	c_read_done: cover property (
		q.st == ST_LINK && link_done && q.op == OP_READ);
	c_write_timeout: cover property (
		q.st == ST_LINK && tmo_expired && q.op == OP_WRITE);
	c_reload: cover property (reload_req);
	c_boot_done: cover property (q.st == ST_BOOT && loader_done);
	c_soft_reset: cover property (soft_reset && !q.busy);

endmodule

// *** hdl/nv_cmd_pkg.sv ***
// constants, types and helpers for the nonvolatile command control block
// assumes a single 50 MHz clock domain and a 12-bit register byte address
package nv_cmd_pkg;

	// register byte addresses
	localparam logic [11:0] REG_CMD = 12'h1B4;
	localparam logic [11:0] REG_DATA = 12'h1B8;
	localparam logic [11:0] REG_ISTAT = 12'h1C0;
	localparam logic [11:0] REG_IMASK = 12'h1C4;

	// command register field positions
	localparam int unsigned BUSY_BIT = 31;
	localparam int unsigned OP_HI = 30;
	localparam int unsigned OP_LO = 28;
	localparam int unsigned TMO_BIT = 9;
	localparam int unsigned EE_ADDR_W = 9;
	localparam int unsigned DATA_W = 8;

	// operation codes
	localparam logic [2:0] OP_READ = 3'h0;
	localparam logic [2:0] OP_WRITE = 3'h3;
	localparam logic [2:0] OP_RELOAD = 3'h7;

	// interrupt status bit positions
	localparam int unsigned IRQ_DONE = 0;
	localparam int unsigned IRQ_TMO = 1;
	localparam int unsigned IRQ_BOOT = 2;
	localparam int unsigned IRQ_W = 3;

	// reset values
	localparam logic BUSY_RST = 1'b1;
	localparam logic [2:0] OP_RST = 3'h0;
	localparam logic [IRQ_W-1:0] IMASK_RST = 3'h0;

	// timing
	localparam int unsigned CLK_PERIOD_NS = 20;
	localparam int unsigned TIMEOUT_NS = 30000000;
	localparam int unsigned TIMEOUT_CYCLES = TIMEOUT_NS / CLK_PERIOD_NS;
	localparam int unsigned TMR_W = 21;

	typedef logic [TMR_W-1:0] tmr_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_LINK = 2'b01,
		ST_BOOT = 2'b10
	} ctl_state_e;

	typedef struct packed {
		ctl_state_e st;
		logic busy;
		logic [2:0] op;
		logic [EE_ADDR_W-1:0] ee_addr;
		logic tmo;
		logic [DATA_W-1:0] data;
		logic [IRQ_W-1:0] istat;
		logic [IRQ_W-1:0] imask;
		logic [31:0] rdata;
		logic link_start;
		logic reload_req;
	} ctl_s;

	localparam ctl_s CTL_RST = '{
		st: ST_BOOT,
		busy: BUSY_RST,
		op: OP_RST,
		ee_addr: 9'h000,
		tmo: 1'b0,
		data: 8'h00,
		istat: 3'h0,
		imask: IMASK_RST,
		rdata: 32'h0000_0000,
		link_start: 1'b0,
		reload_req: 1'b0
	};

	typedef struct packed {
		tmr_t cnt;
		logic expired;
	} tmr_s;

	// operations that reach the serial link
	function automatic logic op_uses_link(input logic [2:0] op);
		return (op == OP_READ) || (op == OP_WRITE);
	endfunction

	// any operation the controller acts on at all
	function automatic logic op_known(input logic [2:0] op);
		return op_uses_link(op) || (op == OP_RELOAD);
	endfunction

endpackage

// *** hdl/nv_timeout_timer.sv ***
// no-answer watchdog for one serial link operation
// assumes run stays high for the whole wait and drops once it ends
module nv_timeout_timer
#(
	parameter int unsigned LIMIT = nv_cmd_pkg::TIMEOUT_CYCLES
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic run,
	output logic expired
);

	import nv_cmd_pkg::*;

	tmr_s q;
	tmr_s d;

	// counts only while waiting; restart is free since run drops between ops
	always_comb begin
		d = q;
		d.expired = 1'b0;
		if (!run) begin
			d.cnt = '0;
		end else if (q.cnt == tmr_t'(LIMIT - 1)) begin
			d.expired = 1'b1;
			d.cnt = '0;
		end else begin
			d.cnt = q.cnt + tmr_t'(1);
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
		end else if (ce) begin
			q <= d;
		end
	end

	assign expired = q.expired;

endmodule

// *** bench/nv_link_model.sv ***
// behavioural serial memory standing behind the link engine ports
// assumes one clock; answers DLY+1 cycles after a start, or stays silent
module nv_link_model #(
	parameter int DLY = 3
) (
	input wire logic clk,
	input wire logic present,
	input wire logic link_start,
	input wire logic link_write,
	input wire logic [8:0] link_addr,
	input wire logic [7:0] link_wdata,
	output logic link_done,
	output logic [7:0] link_rdata
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] mem [512];
	logic [8:0] a;
	logic w;
	logic [7:0] wd;
	int cnt = -1;
	// fill with a pattern tied to the address
	initial begin
		link_done = 1'b0;
		link_rdata = 8'h00;
		foreach (mem[i]) mem[i] = 8'(i) ^ 8'hA5;
	end
	// an absent memory never answers, so the watchdog must end the op
	always @(posedge clk) begin
		link_done <= 1'b0;
		link_rdata <= ~link_rdata; // released data never holds
		if (link_start && present) begin
			a <= link_addr;
			w <= link_write;
			wd <= link_wdata;
			cnt <= DLY;
		end else if (cnt > 0) begin
			cnt <= cnt - 1;
		end else if (cnt == 0) begin
			cnt <= -1;
			link_done <= 1'b1;
			if (w) mem[a] <= wd;
			else link_rdata <= mem[a];
		end
	end
endmodule

// *** bench/eeprom_command_control_bench.sv ***
// self-checking bench for the nonvolatile command control block
// assumes the link model beside it and a shortened timeout of 20 cycles
module eeprom_command_control_bench;
	timeunit 1ns;
	timeprecision 1ns;
	import nv_cmd_pkg::*;
`define CHK(g, e) \
	begin \
		samples_checked++; \
		if ((g) !== (e)) begin \
			mismatches++; \
			$display("[ERR] t=%0t got=%0h exp=%0h", $time, g, e); \
		end \
	end
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [11:0] reg_addr = 12'h000;
	logic [31:0] reg_wdata = 32'h0000_0000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [31:0] reg_rdata;
	logic soft_reset = 1'b0;
	logic loader_done = 1'b0;
	logic present = 1'b1;
	logic link_nack = 1'b0;
	logic reload_req, link_start, link_write, link_done, irq;
	logic [8:0] link_addr;
	logic [7:0] link_wdata, link_rdata;
	int mismatches = 0;
	int samples_checked = 0;
	int starts = 0;
	int reloads = 0;
	logic [31:0] d;

	always #10 clk = ~clk;
	// count pulses that the tasks cannot catch in time
	always @(posedge clk) begin
		if (link_start === 1'b1) starts++;
		if (reload_req === 1'b1) reloads++;
	end

	nv_command_control #(.TIMEOUT_LIMIT(20)) dut_u (.clk(clk),
		.rst_n(rst_n), .ce(1'b1), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .soft_reset(soft_reset),
		.loader_done(loader_done), .reload_req(reload_req),
		.link_start(link_start), .link_write(link_write),
		.link_addr(link_addr), .link_wdata(link_wdata),
		.link_done(link_done), .link_nack(link_nack),
		.link_rdata(link_rdata), .irq(irq));
	nv_link_model mem_u (.clk(clk), .present(present),
		.link_start(link_start), .link_write(link_write),
		.link_addr(link_addr), .link_wdata(link_wdata),
		.link_done(link_done), .link_rdata(link_rdata));

	task automatic give_verdict();
		$display("checks=%0d mismatches=%0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] v);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	// read data stands only in the cycle after the strobe
	task automatic rd(input logic [11:0] a, output logic [31:0] v);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
	endtask
	// poll busy with a bound; the last word read is left in d
	task automatic wait_idle();
		for (int i = 0; i < 40; i++) begin
			rd(REG_CMD, d);
			if (d[BUSY_BIT] === 1'b0) return;
		end
		mismatches++;
		give_verdict();
	endtask
	task automatic boot_done();
		@(posedge clk);
		loader_done <= 1'b1;
		@(posedge clk);
		loader_done <= 1'b0;
		wait_idle();
	endtask
	task automatic t_boot();
		rd(REG_CMD, d);
		`CHK(d[BUSY_BIT], 1'b1);
		boot_done();
	endtask
	task automatic t_access();
		wr(REG_DATA, 32'h0000_003C);
		wr(REG_CMD, 32'hB000_0010);
		wait_idle();
		wr(REG_CMD, 32'h8000_0010);
		wait_idle();
		rd(REG_DATA, d);
		`CHK(d[7:0], 8'h3C);
		wr(REG_CMD, 32'h8000_0005);
		rd(REG_CMD, d);
		`CHK(d[BUSY_BIT], 1'b1);
		wait_idle();
		rd(REG_DATA, d);
		`CHK(d[7:0], 8'h05 ^ 8'hA5);
	endtask
	task automatic t_timeout();
		present <= 1'b0;
		wr(REG_CMD, 32'hB000_0001);
		// mask stays writable while busy
		wr(REG_IMASK, 32'h0000_0002);
		rd(REG_CMD, d);
		`CHK(d[TMO_BIT], 1'b0);
		`CHK(d[BUSY_BIT], 1'b1);
		wait_idle();
		`CHK(d[TMO_BIT], 1'b1);
		`CHK(irq, 1'b1);
		rd(REG_ISTAT, d);
		`CHK(d[IRQ_TMO], 1'b1);
		`CHK(irq, 1'b0);
		wr(REG_CMD, 32'h0000_0200);
		rd(REG_CMD, d);
		`CHK(d[TMO_BIT], 1'b0);
		// a refused answer ends the write long before the watchdog
		wr(REG_CMD, 32'hB000_0002);
		@(posedge clk);
		link_nack <= 1'b1;
		@(posedge clk);
		link_nack <= 1'b0;
		rd(REG_CMD, d);
		`CHK({d[BUSY_BIT], d[TMO_BIT]}, 2'b01);
		wr(REG_CMD, 32'h0000_0200);
		present <= 1'b1;
	endtask
	// reserved codes must neither start the link nor set busy
	task automatic t_reserved();
		logic [2:0] codes [5] = '{3'h1, 3'h2, 3'h4, 3'h5, 3'h6};
		int s0;
		s0 = starts;
		foreach (codes[i]) begin
			wr(REG_CMD, {1'b1, codes[i], 28'h000_0007});
			rd(REG_CMD, d);
			`CHK(d[BUSY_BIT], 1'b0);
		end
		`CHK(starts, s0);
		rd(12'h1D0, d);
		`CHK(d, 32'h0000_0000);
	endtask
	task automatic t_soft();
		wr(REG_CMD, 32'hF000_0000);
		// the pulse is launched at the edge the write task returns on
		#1;
		`CHK(reload_req, 1'b1);
		@(posedge clk);
		#1;
		`CHK(reloads, 1);
		boot_done();
		@(posedge clk);
		soft_reset <= 1'b1;
		@(posedge clk);
		soft_reset <= 1'b0;
		rd(REG_CMD, d);
		`CHK(d[BUSY_BIT], 1'b1);
		boot_done();
	endtask

	initial begin
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		t_boot();
		t_access();
		t_timeout();
		t_reserved();
		t_soft();
		give_verdict();
	end
endmodule
